// ===== cam_ctrl_pkg.sv
// constants, settings type and rule summary for the camera mode and capture controller
// Operation
// [RULE1] mode 0 gives live video with shutter, async reset and freeze all off
// [RULE2] mode 1 steps gain of both channels, floor 8 dB, ceiling limit default 28 dB
// [RULE3] mode 2 up selects manual shutter, down selects async reset shutter
// [RULE4] async: discharge while trigger high, falling edge resets timing and captures frame
// [RULE5] async: video off while trigger high until the first frame is captured
// [RULE6] modes 3 and 4 recall 9, 16, 22 or 28 dB
// [RULE7] mode 5 moves both black offsets by one step
// [RULE8] mode 6 moves only the second channel offset
// [RULE9] mode 7 down enables auto shutter, up restores switch shutter
// [RULE10] mode 8 up gives live video, down freezes the stored frame
// [RULE11] freeze: integrate while input low, capture and hold on its rising edge
// [RULE12] live: hold previous image while integrating, then show one integrated frame
// [RULE13] frame valid low during integration, vertical timing restarts at output
// [RULE14] page 9 recalls factory data and is never written
// [RULE15] power-up loads page A unless B to F selected; A changes only on save
// [RULE16] pages B to F: up saves current settings, down loads them
// [RULE17] page A with switch up at power-up enters calibration, auto save, exit by reset
// [RULE18] manual shutter: position 0 off, 1 to 9 halve from 1/60 s to 1/16000 s
// [RULE19] async shutter: positions 1 to 8 give 1H doubling to 128H, 9 pulse width
// [RULE20] stored frame keeps playing until the next capture completes
// [RULE21] 10-bit progressive video words at 40 MHz
// [RULE22] interlace format: two rows shown, two rows skipped, repeating
// [RULE23] pulse width: discharge at ninth line drive after fall, reset timing at rise
// [RULE24] up/down switch debounced, one action per press
// [RULE25] mode selector 0 to F routes actions only to the selected function
package cam_ctrl_pkg;
   localparam int CLK_MHZ = 200;
   localparam int PIX_MHZ = 40;
   localparam int PIX_DIV = CLK_MHZ / PIX_MHZ;
   localparam int DEBOUNCE_MS = 10;
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_MHZ * 1000;
   localparam int INIT_CYC = 6;
   localparam int PW_DISCHARGE_LINE = 9;
   // pin vector layout after synchronising
   localparam int PIN_W = 13;
   localparam int PIN_MODE_LSB = 0;
   localparam int PIN_SHUT_LSB = 4;
   localparam int PIN_UP = 8;
   localparam int PIN_DOWN = 9;
   localparam int PIN_ASYNC = 10;
   localparam int PIN_INTEGRATION_CONTROL = 11;
   localparam int PIN_HD = 12;
   localparam logic [PIN_W-1:0] PIN_RST = 13'h0C00;
   // gains in dB
   localparam logic [7:0] GAIN_MIN_DB = 8'h08;
   localparam logic [7:0] GAIN_LIMIT_RST = 8'h1C;
   localparam logic [7:0] GAIN_P3_UP = 8'h09;
   localparam logic [7:0] GAIN_P3_DOWN = 8'h10;
   localparam logic [7:0] GAIN_P4_UP = 8'h16;
   localparam logic [7:0] GAIN_P4_DOWN = 8'h1C;
   localparam logic [7:0] OFFSET_STEP = 8'h01;
   localparam logic [7:0] OFFSET_RST = 8'h80;
   // selector codes
   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [3:0] MODE_GAIN = 4'h1;
   localparam logic [3:0] MODE_SHTYPE = 4'h2;
   localparam logic [3:0] MODE_PRESET_LO = 4'h3;
   localparam logic [3:0] MODE_PRESET_HI = 4'h4;
   localparam logic [3:0] MODE_OFS_BOTH = 4'h5;
   localparam logic [3:0] MODE_OFS_B = 4'h6;
   localparam logic [3:0] MODE_AUTO = 4'h7;
   localparam logic [3:0] MODE_FREEZE = 4'h8;
   localparam logic [3:0] PAGE_FACTORY = 4'h9;
   localparam logic [3:0] PAGE_USER_DEF = 4'hA;
   localparam logic [3:0] PAGE_USER_FIRST = 4'hB;
   localparam logic [3:0] SHUT_OFF = 4'h0;
   localparam logic [3:0] SHUT_PULSE = 4'h9;
   // register byte offsets and control fields
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_SETTINGS = 4'h8;
   localparam int CTRL_INTERLACE_BIT = 0;
   localparam int CTRL_LIMIT_LSB = 8;
   localparam logic CTRL_INTERLACE_RST = 1'b0;

   typedef struct packed {
      logic [7:0] gain;
      logic [7:0] off_a;
      logic [7:0] off_b;
      logic async_sh;
      logic auto_sh;
      logic freeze;
   } settings_t;

   localparam settings_t FACTORY_SET = '{gain: GAIN_MIN_DB, off_a: OFFSET_RST, off_b: OFFSET_RST,
      async_sh: 1'b0, auto_sh: 1'b0, freeze: 1'b0};

   // manual exposure in microseconds per switch position
   function automatic logic [15:0] manual_exposure_us(input logic [3:0] pos);
      case (pos)
         4'h1: return 16'h411B;
         4'h2: return 16'h1F40;
         4'h3: return 16'h0FA0;
         4'h4: return 16'h07D0;
         4'h5: return 16'h03E8;
         4'h6: return 16'h01F4;
         4'h7: return 16'h00FA;
         4'h8: return 16'h007D;
         4'h9: return 16'h003F;
         default: return 16'h0000;
      endcase
   endfunction : manual_exposure_us
endpackage : cam_ctrl_pkg

// ===== cam_ctrl.sv
// camera mode selector, settings pages, capture sequencing and video output timing
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module cam_ctrl
   import cam_ctrl_pkg::*;
#(
   parameter int LINE_PIX = 1024,
   parameter int FRAME_LINES = 1024,
   parameter int PIX_W = 10,
   parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
)(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // avalon-mm register slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // panel switches
   input wire logic [3:0] mode_select,
   input wire logic [3:0] shutter_select,
   input wire logic switch_up,
   input wire logic switch_down,
   // trigger and timing pins
   input wire logic async_reset_pulse,
   input wire logic integration_control_n,
   input wire logic line_drive_ref,
   // sensor samples on clk
   input wire logic [PIX_W-1:0] sensor_pix,
   // analog and shutter controls
   output logic [7:0] gain_db,
   output logic [7:0] offset_a,
   output logic [7:0] offset_b,
   output logic auto_shutter,
   output logic freeze_select,
   output logic shutter_enable,
   output logic exposure_in_lines,
   output logic [15:0] exposure_value,
   output logic sensor_discharge,
   output logic calibration_active,
   // video out
   output logic [PIX_W-1:0] pixel_data,
   output logic pixel_strobe,
   output logic line_valid_out,
   output logic frame_valid_out
);
   localparam int DEB_W = $clog2(DEBOUNCE_CYCLES + 1);
   localparam int PC_W = $clog2(LINE_PIX + 1);
   localparam int LC_W = $clog2(FRAME_LINES + 1);
   localparam int AW = $clog2(LINE_PIX * FRAME_LINES);
   localparam int DIV_W = $clog2(PIX_DIV);

   typedef struct packed {
      logic [PIN_W-1:0] s1;
      logic [PIN_W-1:0] s2;
      logic [PIN_W-1:0] s3;
      logic [PIN_W-1:0] pins;
      logic [DEB_W-1:0] deb_cnt;
      logic [1:0] sw;
      logic [3:0] init_cnt;
      logic init_done;
      logic calib;
      settings_t cur;
      settings_t [15:0] pages;
      logic [7:0] limit;
      logic interlace;
      logic captured_any;
      logic integrating;
      logic cap_pend;
      logic cap_active;
      logic pw_wait;
      logic [3:0] pw_cnt;
      logic hd_prev;
      logic async_prev;
      logic integration_control_prev;
      logic [DIV_W-1:0] div;
      logic [PC_W-1:0] pix;
      logic [LC_W-1:0] line;
      logic in_line;
      logic [PIX_W-1:0] pix_out;
      logic strobe;
      logic lv;
      logic fv;
      logic discharge;
      logic ack;
      logic [31:0] rdata;
   } state_t;

   state_t s;
   state_t n;
   logic [PIX_W-1:0] frame_mem [LINE_PIX*FRAME_LINES];
   logic [PIX_W-1:0] mem_q;
   logic [AW-1:0] addr;
   logic mem_we;
   logic up_act;
   logic down_act;
   logic use_mem;
   logic vid_en;
   logic eff_async;
   logic pw_fire;
   logic [3:0] mode;
   logic [3:0] shut_pos;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   function automatic logic [7:0] ofs_step(input logic [7:0] v, input logic up);
      if (up)
         return (v == 8'hFF) ? v : v + OFFSET_STEP;
      return (v == 8'h00) ? v : v - OFFSET_STEP;
   endfunction : ofs_step

   assign mode = s.pins[PIN_MODE_LSB +: 4];
   assign shut_pos = s.pins[PIN_SHUT_LSB +: 4];
   assign addr = AW'(s.line * LINE_PIX + s.pix);

   always_comb
   begin
      logic [PIN_W-1:0] agree;
      logic [1:0] raw;
      logic accept;
      logic hd_edge;
      logic async_fall;
      logic async_rise;
      logic integration_control_rise;
      logic bus_req;
      logic trig;
      agree = '0;
      raw = '0;
      accept = 1'b0;
      hd_edge = 1'b0;
      async_fall = 1'b0;
      async_rise = 1'b0;
      integration_control_rise = 1'b0;
      bus_req = 1'b0;
      trig = 1'b0;
      n = s;
      // the first stage feeds only the second
      n.s1 = {line_drive_ref, integration_control_n, async_reset_pulse, switch_down, switch_up,
         shutter_select, mode_select};
      n.s2 = s.s1;
      n.s3 = s.s2;
      agree = ~(s.s2 ^ s.s3);
      n.pins = (agree & s.s3) | (~agree & s.pins);
      n.hd_prev = s.pins[PIN_HD];
      n.async_prev = s.pins[PIN_ASYNC];
      n.integration_control_prev = s.pins[PIN_INTEGRATION_CONTROL];
      hd_edge = s.pins[PIN_HD] & ~s.hd_prev;
      async_fall = ~s.pins[PIN_ASYNC] & s.async_prev & s.init_done;
      async_rise = s.pins[PIN_ASYNC] & ~s.async_prev & s.init_done;
      integration_control_rise = s.pins[PIN_INTEGRATION_CONTROL] & ~s.integration_control_prev & s.init_done;

      // debounce: a new switch level must hold for the full window
      raw = {s.pins[PIN_DOWN], s.pins[PIN_UP]};
      if (raw != s.sw)
      begin
         n.deb_cnt = s.deb_cnt + 1'b1;
         if (s.deb_cnt == DEB_W'(DEBOUNCE_CYCLES - 1))
         begin
            accept = 1'b1;
            n.sw = raw;
            n.deb_cnt = '0;
         end
      end
      else
         n.deb_cnt = '0;
      // both held at once is ambiguous and gives no action
      up_act = accept & s.init_done & raw[0] & ~s.sw[0] & ~raw[1]; // see [RULE24]
      down_act = accept & s.init_done & raw[1] & ~s.sw[1] & ~raw[0]; // see [RULE24]

      // power-up page load waits for the synchronisers to settle
      if (!s.init_done)
      begin
         n.init_cnt = s.init_cnt + 1'b1;
         if (s.init_cnt == 4'(INIT_CYC - 1))
         begin
            n.init_done = 1'b1;
            n.cur = (mode >= PAGE_USER_FIRST) ? s.pages[mode] : s.pages[PAGE_USER_DEF]; // see [RULE15]
            n.calib = (mode == PAGE_USER_DEF) & s.pins[PIN_UP]; // see [RULE17]
         end
      end

      // each action reaches only the function of the selected code
      if (up_act | down_act)
      begin
         unique case (mode) // see [RULE25]
            MODE_NORMAL: ;
            MODE_GAIN:
               if (up_act && s.cur.gain < s.limit)
                  n.cur.gain = s.cur.gain + 8'h01; // see [RULE2]
               else if (down_act && s.cur.gain > GAIN_MIN_DB)
                  n.cur.gain = s.cur.gain - 8'h01; // see [RULE2]
            MODE_SHTYPE: n.cur.async_sh = down_act; // see [RULE3]
            MODE_PRESET_LO: n.cur.gain = up_act ? GAIN_P3_UP : GAIN_P3_DOWN; // see [RULE6]
            MODE_PRESET_HI: n.cur.gain = up_act ? GAIN_P4_UP : GAIN_P4_DOWN; // see [RULE6]
            MODE_OFS_BOTH:
            begin
               n.cur.off_a = ofs_step(s.cur.off_a, up_act); // see [RULE7]
               n.cur.off_b = ofs_step(s.cur.off_b, up_act); // see [RULE7]
            end
            MODE_OFS_B: n.cur.off_b = ofs_step(s.cur.off_b, up_act); // see [RULE8]
            MODE_AUTO: n.cur.auto_sh = down_act; // see [RULE9]
            MODE_FREEZE: n.cur.freeze = down_act; // see [RULE10]
            PAGE_FACTORY: n.cur = FACTORY_SET; // see [RULE14]
            default:
               if (up_act)
                  n.pages[mode] = s.cur; // see [RULE16]
               else
                  n.cur = s.pages[mode]; // see [RULE16]
         endcase
      end
      // calibration mirrors every change into the default page
      if (s.calib)
         n.pages[PAGE_USER_DEF] = n.cur; // see [RULE17]

      // trigger handling
      eff_async = s.cur.async_sh & (mode != MODE_NORMAL) & s.init_done; // see [RULE1]
      pw_fire = 1'b0;
      n.integrating = ~s.pins[PIN_INTEGRATION_CONTROL] & s.init_done;
      if (eff_async && async_fall)
      begin
         if (shut_pos == SHUT_PULSE)
         begin
            n.pw_wait = 1'b1;
            n.pw_cnt = '0;
         end
         else
            n.cap_pend = 1'b1; // see [RULE4]
      end
      if (eff_async && s.pw_wait && hd_edge)
      begin
         n.pw_cnt = s.pw_cnt + 4'h1;
         if (s.pw_cnt == 4'(PW_DISCHARGE_LINE - 1))
         begin
            pw_fire = 1'b1; // see [RULE23]
            n.pw_wait = 1'b0;
         end
      end
      if (eff_async && async_rise && shut_pos == SHUT_PULSE)
         n.cap_pend = 1'b1; // see [RULE23]
      if (integration_control_rise)
         n.cap_pend = 1'b1; // see [RULE11]
      // a trigger in the cycle a capture starts must not be swallowed by that start
      trig = (eff_async & async_fall & (shut_pos != SHUT_PULSE)) |
         (eff_async & async_rise & (shut_pos == SHUT_PULSE)) | integration_control_rise;
      n.discharge = eff_async & ((s.pins[PIN_ASYNC] & ~s.cap_pend & ~s.cap_active) | pw_fire); // see [RULE4]

      // line timing locked to the external line drive
      if (hd_edge)
      begin
         n.in_line = 1'b1;
         n.pix = '0;
         if (s.cap_pend && !s.integrating)
         begin
            n.line = '0; // see [RULE13]
            n.cap_pend = trig;
            n.cap_active = 1'b1;
         end
         else if (s.line == LC_W'(FRAME_LINES - 1))
         begin
            n.line = '0;
            if (s.cap_active)
            begin
               n.cap_active = 1'b0;
               n.captured_any = 1'b1;
            end
         end
         else
            n.line = s.line + 1'b1;
      end
      n.strobe = (s.div == DIV_W'(PIX_DIV - 1)); // see [RULE21]
      n.div = n.strobe ? '0 : s.div + 1'b1;
      if (s.strobe && s.in_line && !hd_edge)
      begin
         n.pix = s.pix + 1'b1;
         if (s.pix == PC_W'(LINE_PIX - 1))
            n.in_line = 1'b0;
      end

      // source choice: memory holds the last capture until the next one completes
      use_mem = eff_async | (s.cur.freeze & (mode != MODE_NORMAL)) | s.integrating; // see [RULE20]
      vid_en = ~(eff_async & ~s.captured_any & s.pins[PIN_ASYNC]) & ~s.integrating; // see [RULE5]
      mem_we = s.strobe & s.in_line & (~use_mem | s.cap_active) & ~s.integrating;
      if (s.strobe)
         n.pix_out = use_mem ? mem_q : sensor_pix; // see [RULE10] [RULE12]
      n.lv = s.in_line & vid_en & (~s.interlace | ~s.line[1]); // see [RULE22]
      n.fv = vid_en; // see [RULE13]

      // bus slave: one wait state, then the answer
      bus_req = avs_read | avs_write;
      n.ack = bus_req & ~s.ack;
      if (!s.ack)
      begin
         unique case (avs_address)
            REG_CTRL: n.rdata = {16'h0000, s.limit, 7'h00, s.interlace};
            REG_STATUS: n.rdata = {17'h00000, s.cur.freeze, s.cur.auto_sh, s.cur.async_sh,
               s.cap_pend | s.cap_active, s.calib, s.integrating, s.captured_any, shut_pos, mode};
            REG_SETTINGS: n.rdata = {8'h00, s.cur.off_b, s.cur.off_a, s.cur.gain};
            default: n.rdata = 32'h0000_0000;
         endcase
      end
      if (avs_write && s.ack && avs_address == REG_CTRL)
      begin
         n.interlace = avs_writedata[CTRL_INTERLACE_BIT];
         n.limit = avs_writedata[CTRL_LIMIT_LSB +: 8];
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s <= '0;
         s.s1 <= PIN_RST;
         s.s2 <= PIN_RST;
         s.s3 <= PIN_RST;
         s.pins <= PIN_RST;
         s.integration_control_prev <= 1'b1;
         s.async_prev <= 1'b1;
         s.cur <= FACTORY_SET;
         s.pages <= {16{FACTORY_SET}};
         s.limit <= GAIN_LIMIT_RST;
         s.interlace <= CTRL_INTERLACE_RST;
      end
      else
         s <= n;
   end

   // frame store; no reset, contents are undefined until first written
   always_ff @(posedge clk)
   begin
      if (mem_we)
         frame_mem[addr] <= sensor_pix;
      mem_q <= frame_mem[addr];
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~s.ack;
   assign avs_readdata = s.rdata;
   assign gain_db = s.cur.gain;
   assign offset_a = s.cur.off_a;
   assign offset_b = s.cur.off_b;
   assign auto_shutter = s.cur.auto_sh & (mode != MODE_NORMAL); // see [RULE9]
   assign freeze_select = s.cur.freeze & (mode != MODE_NORMAL);
   assign shutter_enable = (shut_pos != SHUT_OFF) & (mode != MODE_NORMAL); // see [RULE18]
   assign exposure_in_lines = eff_async;
   // async positions double from one line; pulse width position leaves the count at zero
   assign exposure_value = eff_async ? ((shut_pos == SHUT_OFF || shut_pos == SHUT_PULSE) ? 16'h0000 :
      16'h0001 << (shut_pos - 4'h1)) : manual_exposure_us(shut_pos); // see [RULE18] [RULE19]
   assign sensor_discharge = s.discharge;
   assign calibration_active = s.calib;
   assign pixel_data = s.pix_out;
   assign pixel_strobe = s.strobe;
   assign line_valid_out = s.lv;
   assign frame_valid_out = s.fv;

   sequence strobe_gap_s;
      !pixel_strobe [*4] ##1 pixel_strobe;
   endsequence

   sequence gain_action_s;
      up_act && mode == MODE_GAIN && s.cur.gain < s.limit;
   endsequence

   mode0_live_a: assert property (s.init_done && mode == MODE_NORMAL |-> !use_mem ##1 !sensor_discharge) // see [RULE1]
      else $error("mode 0 is not live video");
   gain_step_a: assert property (gain_action_s |=> gain_db == $past(s.cur.gain) + 8'h01) // see [RULE2]
      else $error("gain did not step by one dB");
   gain_floor_a: assert property (gain_db >= GAIN_MIN_DB) // see [RULE2]
      else $error("gain below floor");
   shut_type_a: assert property (down_act && mode == MODE_SHTYPE |=> s.cur.async_sh) // see [RULE3]
      else $error("async shutter not selected");
   discharge_a: assert property (eff_async && s.pins[PIN_ASYNC] && !s.cap_pend && !s.cap_active
      |=> sensor_discharge) // see [RULE4]
      else $error("sensor not discharged while trigger high");
   preset_gain_a: assert property (up_act && mode == MODE_PRESET_LO |=> gain_db == GAIN_P3_UP) // see [RULE6]
      else $error("preset gain wrong");
   offset_b_a: assert property ((up_act || down_act) && mode == MODE_OFS_B |=> $stable(offset_a)) // see [RULE8]
      else $error("first channel offset moved");
   factory_ro_a: assert property (up_act |=> s.pages[PAGE_FACTORY] == FACTORY_SET) // see [RULE14]
      else $error("factory page altered");
   integration_control_fv_a: assert property (s.integrating |=> !frame_valid_out) // see [RULE13]
      else $error("frame valid during integration");
   strobe_rate_a: assert property (pixel_strobe |=> strobe_gap_s) // see [RULE21]
      else $error("pixel strobe not one in five cycles");
   skip_rows_a: assert property (s.interlace && s.line[1] |=> !line_valid_out) // see [RULE22]
      else $error("skipped row shown");
endmodule : cam_ctrl

// ===== cam_source.sv
// trigger and line drive source standing in for the frame grabber side
`timescale 1ns/1ps
module cam_source (
   // requests from the bench
   input wire logic fire_async,
   input wire logic integration_control_on,
   // pins toward the camera
   output logic line_drive_ref,
   output logic async_reset_pulse,
   output logic integration_control_n
);
   // line drive runs free with a 125 ns period, at a fixed phase to the camera clock
   initial
   begin
      line_drive_ref = 1'b0;
      // phase offset keeps its edges clear of the camera clock edges
      #1.5;
      forever #62.5 line_drive_ref = ~line_drive_ref;
   end
   // trigger pins idle high; low only while the bench asks
   assign async_reset_pulse = ~fire_async;
   assign integration_control_n = ~integration_control_on;
endmodule : cam_source

// ===== cam_ctrl_test.sv
// self-checking bench for the camera mode and capture controller
`timescale 1ns/1ps
module cam_ctrl_test;
   import cam_ctrl_pkg::*;
   localparam int DEB = 8;
   logic clk, srst, avs_read, avs_write, avs_waitrequest, switch_up, switch_down;
   logic [3:0] avs_address, mode_select, shutter_select, pos;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [9:0] sensor_pix, pixel_data;
   logic [7:0] gain_db, offset_a, offset_b;
   logic [15:0] exposure_value;
   logic auto_shutter, freeze_select, shutter_enable, exposure_in_lines, sensor_discharge;
   logic calibration_active, pixel_strobe, line_valid_out, frame_valid_out;
   logic line_drive_ref, async_reset_pulse, integration_control_n, fire_async, integration_control_on, seen;
   int errors = 0;
   int samples_checked = 0;
   int cnt;

   cam_ctrl #(.LINE_PIX(8), .FRAME_LINES(8), .DEBOUNCE_CYCLES(DEB)) u_dut (.clk, .srst,
      .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
      .mode_select, .shutter_select, .switch_up, .switch_down, .async_reset_pulse,
      .integration_control_n, .line_drive_ref, .sensor_pix, .gain_db, .offset_a, .offset_b,
      .auto_shutter, .freeze_select, .shutter_enable, .exposure_in_lines, .exposure_value,
      .sensor_discharge, .calibration_active, .pixel_data, .pixel_strobe, .line_valid_out,
      .frame_valid_out);
   cam_source u_src (.fire_async, .integration_control_on, .line_drive_ref, .async_reset_pulse, .integration_control_n);

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) sensor_pix <= 10'($urandom);

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~w;
      avs_write <= w;
      @(posedge clk);
      // only the watchdog ends a wait that never finishes
      while (avs_waitrequest !== 1'b0)
         @(posedge clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   // press holds well past the debounce span so one press gives one action
   task press(input logic up);
      @(posedge clk);
      switch_up <= up;
      switch_down <= ~up;
      repeat (DEB + 14) @(posedge clk);
      switch_up <= 1'b0;
      switch_down <= 1'b0;
      repeat (DEB + 14) @(posedge clk);
   endtask : press

   task set_mode(input logic [3:0] m);
      @(posedge clk);
      mode_select <= m;
      repeat (8) @(posedge clk);
   endtask : set_mode

   task do_reset(input logic up);
      @(posedge clk);
      mode_select <= PAGE_USER_DEF;
      switch_up <= up;
      srst <= 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      repeat (24) @(posedge clk);
   endtask : do_reset

   function automatic logic [7:0] preset_gain(input int i);
      case (i)
         0: return 8'h09;
         1: return 8'h10;
         2: return 8'h16;
         default: return 8'h1C;
      endcase
   endfunction : preset_gain

   task final_report;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report

   initial
   begin
      #100000;
      errors++;
      final_report;
   end

   initial
   begin
      {srst, avs_read, avs_write, switch_up, switch_down, fire_async, integration_control_on} = 7'h01 << 6;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      mode_select = PAGE_USER_DEF;
      shutter_select = 4'h0;
      sensor_pix = 10'h000;
      void'($urandom(32'h96EF));
      do_reset(1'b0);
      chk("gain_rst", 32'h08, gain_db);
      chk("ofs_rst", 32'h8080, {offset_a, offset_b});
      bus(1'b0, REG_CTRL, 32'h0, rd);
      chk("ctrl_rst", 32'h00001C00, rd);
      bus(1'b1, REG_CTRL, 32'h00001C01, rd);
      bus(1'b0, REG_CTRL, 32'h0, rd);
      chk("ctrl_rw", 32'h00001C01, rd);
      bus(1'b1, 4'hC, 32'hFFFFFFFF, rd);
      bus(1'b0, 4'hC, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      bus(1'b1, REG_SETTINGS, 32'hFFFFFFFF, rd);
      bus(1'b0, REG_SETTINGS, 32'h0, rd);
      chk("settings_ro", 32'h00808008, rd);
      cnt = 0;
      repeat (50)
      begin
         @(posedge clk);
         cnt += int'(pixel_strobe === 1'b1);
      end
      chk("strobes", 32'd10, cnt);
      // interlace is on: eight lines of 25 clocks per frame, rows 2, 3, 6 and 7 hidden
      cnt = 0;
      repeat (200)
      begin
         @(posedge clk);
         cnt += int'(line_valid_out === 1'b1);
      end
      chk("lv_interlace", 32'd100, cnt);
      $display("test registers done");
      set_mode(MODE_GAIN);
      press(1'b0);
      chk("gain_floor", 32'h08, gain_db);
      repeat ($urandom_range(1, 3)) press(1'b1);
      chk("gain_up", 32'h1, {31'h0, gain_db > GAIN_MIN_DB});
      for (int i = 0; i < 4; i++)
      begin
         set_mode(i < 2 ? MODE_PRESET_LO : MODE_PRESET_HI);
         press(i[0] == 1'b0);
         chk("preset", preset_gain(i), gain_db);
      end
      set_mode(MODE_GAIN);
      press(1'b1);
      chk("gain_ceiling", 32'h1C, gain_db);
      set_mode(MODE_OFS_BOTH);
      press(1'b1);
      chk("ofs_both", 32'h8181, {offset_a, offset_b});
      set_mode(MODE_OFS_B);
      press(1'b0);
      chk("ofs_b", 32'h8180, {offset_a, offset_b});
      set_mode(MODE_AUTO);
      press(1'b0);
      chk("auto_on", 32'h1, auto_shutter);
      press(1'b1);
      chk("auto_off", 32'h0, auto_shutter);
      press(1'b0);
      set_mode(MODE_FREEZE);
      press(1'b0);
      chk("freeze_on", 32'h1, freeze_select);
      set_mode(MODE_NORMAL);
      chk("mode0_gate", 32'h0, {auto_shutter, freeze_select});
      $display("test modes done");
      set_mode(PAGE_USER_FIRST);
      press(1'b1);
      set_mode(MODE_PRESET_LO);
      press(1'b1);
      set_mode(PAGE_USER_FIRST);
      press(1'b0);
      chk("page_load", 32'h1C8180, {gain_db, offset_a, offset_b});
      set_mode(PAGE_FACTORY);
      press(1'b1);
      chk("factory", 32'h088080, {gain_db, offset_a, offset_b});
      $display("test pages done");
      pos = 4'($urandom_range(1, 8));
      shutter_select <= pos;
      set_mode(MODE_SHTYPE);
      press(1'b0);
      chk("exp_lines", 32'h1 << (pos - 1), exposure_value);
      chk("in_lines", 32'h1, exposure_in_lines);
      chk("fv_blank", 32'h0, frame_valid_out);
      chk("discharge", 32'h1, sensor_discharge);
      fire_async <= 1'b1;
      repeat (400) @(posedge clk);
      bus(1'b0, REG_STATUS, 32'h0, rd);
      chk("captured", 32'h1, rd[8]);
      fire_async <= 1'b0;
      // pulse width position: discharge pulse must come at the ninth line drive after the fall
      shutter_select <= SHUT_PULSE;
      repeat (8) @(posedge clk);
      fire_async <= 1'b1;
      repeat (10) @(posedge clk);
      seen = 1'b0;
      repeat (290)
      begin
         @(posedge clk);
         seen |= (sensor_discharge === 1'b1);
      end
      chk("pw_discharge", 32'h1, seen);
      fire_async <= 1'b0;
      press(1'b1);
      shutter_select <= 4'h5;
      repeat (8) @(posedge clk);
      chk("exp_manual", 32'h03E8, exposure_value);
      shutter_select <= SHUT_OFF;
      repeat (8) @(posedge clk);
      chk("shut_off", 32'h0, shutter_enable);
      $display("test shutter done");
      set_mode(MODE_FREEZE);
      press(1'b0);
      integration_control_on <= 1'b1;
      repeat (60) @(posedge clk);
      chk("fv_integration_control", 32'h0, frame_valid_out);
      integration_control_on <= 1'b0;
      seen = 1'b0;
      repeat (600)
      begin
         @(posedge clk);
         seen |= (frame_valid_out === 1'b1);
      end
      chk("fv_resume", 32'h1, seen);
      // a frozen frame repeats every 200 clocks while live samples keep changing
      rd = 32'(pixel_data);
      repeat (200) @(posedge clk);
      chk("frozen_pix", rd, pixel_data);
      $display("test integration done");
      do_reset(1'b1);
      chk("calib", 32'h1, calibration_active);
      switch_up <= 1'b0;
      $display("test calibration done");
      final_report;
   end
endmodule : cam_ctrl_test
